// ---- rtl/rivm_prio_enc.v ----
// lowest-index-first priority picker for pending requests
module rivm_prio_enc #(
  parameter N     = 24,
  parameter IDX_W = 5
) (
  input  wire [N-1:0]     req_i,
  output reg              valid_o,
  output reg  [IDX_W-1:0] idx_o
);

  integer i;

  // scan from the top so the lowest set index is the last one kept
  always @* begin
    valid_o = 1'b0;
    idx_o   = {IDX_W{1'b0}};
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (req_i[i]) begin
        valid_o = 1'b1;
        idx_o   = i[IDX_W-1:0];
      end
    end
  end

endmodule // rivm_prio_enc

// ---- rtl/rivm_regs.vh ----
// constants for the reset and interrupt vector map
//
// Overview of operation
// - any reset source starts execution at word 0x0000 while the reset fuse is unprogrammed.
// - vectors 0x0002, 0x0004, 0x0006 serve external request zero and pin-change groups a, b.
// - vectors 0x0008 and 0x000A serve the second 8-bit timer compare and overflow.
// - vectors 0x000C to 0x0012 serve 16-bit timer capture, compare a, compare b, overflow.
// - vectors 0x0014 and 0x0016 serve the first 8-bit timer compare and overflow.
// - vectors 0x0018 to 0x001E serve spi done, usart receive, buffer empty, transmit.
// - vectors 0x0020 and 0x0022 serve serial unit start condition and counter overflow.
// - vectors 0x0024 to 0x002A serve comparator, conversion, eeprom, store; 0x002C display frame.
// - pin-change groups c and d use 0x002E, 0x0030, present only in large variants.
// - a programmed reset fuse starts execution at the boot loader reset address.
// - with table select set, each vector is its offset plus the boot section start.
// - fuse 1 means unprogrammed; table select 0 or 1 chooses base zero or boot.
// - unlock clears itself four cycles after being written or when select is written.
// - interrupts blocked from unlock set until after next instruction, or four cycles.
`ifndef RIVM_REGS_VH
`define RIVM_REGS_VH

// ----------------------------------------------------------------
// reset and table base
// ----------------------------------------------------------------
`define RIVM_RESET_ADDR      16'h0000
`define RIVM_FUSE_UNPROG     1'b1
`define RIVM_VEC_STRIDE      16'h0002

// ----------------------------------------------------------------
// vector offsets, one per source
// ----------------------------------------------------------------
`define RIVM_VEC_EXT_IRQ_ZERO   16'h0002
`define RIVM_VEC_PC_GROUP_A     16'h0004
`define RIVM_VEC_PC_GROUP_B     16'h0006
`define RIVM_VEC_TB8_COMPARE    16'h0008
`define RIVM_VEC_TB8_OVERFLOW   16'h000A
`define RIVM_VEC_TW16_CAPTURE   16'h000C
`define RIVM_VEC_TW16_COMPARE_A 16'h000E
`define RIVM_VEC_TW16_COMPARE_B 16'h0010
`define RIVM_VEC_TW16_OVERFLOW  16'h0012
`define RIVM_VEC_TA8_COMPARE    16'h0014
`define RIVM_VEC_TA8_OVERFLOW   16'h0016
`define RIVM_VEC_SPI_DONE       16'h0018
`define RIVM_VEC_USART_RX       16'h001A
`define RIVM_VEC_TX_BUF_EMPTY   16'h001C
`define RIVM_VEC_USART_TX       16'h001E
`define RIVM_VEC_USU_START      16'h0020
`define RIVM_VEC_USU_OVERFLOW   16'h0022
`define RIVM_VEC_ANALOG_COMP    16'h0024
`define RIVM_VEC_CONV_DONE      16'h0026
`define RIVM_VEC_EEPROM_READY   16'h0028
`define RIVM_VEC_PROG_STORE_RDY 16'h002A
`define RIVM_VEC_DISPLAY_FRAME  16'h002C
`define RIVM_VEC_PC_GROUP_C     16'h002E
`define RIVM_VEC_PC_GROUP_D     16'h0030

// ----------------------------------------------------------------
// control register fields and timing
// ----------------------------------------------------------------
`define RIVM_CTRL_UNLOCK_BIT    0
`define RIVM_CTRL_SELECT_BIT    1
`define RIVM_CTRL_SELECT_RST    1'b0
`define RIVM_CTRL_UNLOCK_RST    1'b0
`define RIVM_UNLOCK_CYCLES      3'd4
`define RIVM_SRC_COUNT          24
`define RIVM_SRC_LARGE_FIRST    22

`endif

// ---- rtl/rivm_vector_map.v ----
// reset and interrupt vector address generator with table relocation
`include "rivm_regs.vh"

module rivm_vector_map #(
  parameter ADDR_W      = 16,
  parameter N_SRC       = 24,
  parameter IDX_W       = 5,
  parameter LARGE_PINS  = 1
) (
  input  wire              core_clk_i,
  input  wire              rst_b_i,
  input  wire              reset_location_fuse_i,
  input  wire [ADDR_W-1:0] boot_reset_addr_i,
  input  wire              ctrl_wr_i,
  input  wire [1:0]        ctrl_wdata_i,
  input  wire              instr_done_i,
  input  wire              global_irq_enable_i,
  input  wire [N_SRC-1:0]  irq_src_i,
  input  wire              irq_ack_i,
  output reg               reset_fetch_o,
  output reg  [ADDR_W-1:0] reset_addr_o,
  output reg               vector_table_select_o,
  output reg               vector_change_unlock_o,
  output reg               irq_blocked_o,
  output reg               irq_req_o,
  output reg  [IDX_W-1:0]  irq_vector_num_o,
  output reg  [ADDR_W-1:0] irq_vector_addr_o,
  output reg  [N_SRC-1:0]  irq_ack_src_o
);

  // ----------------------------------------------------------------
  // vector offset lookup
  // ----------------------------------------------------------------
  function [15:0] vec_offset;
    input [IDX_W-1:0] idx;
    begin
      case (idx)
        5'd0:  vec_offset = `RIVM_VEC_EXT_IRQ_ZERO;
        5'd1:  vec_offset = `RIVM_VEC_PC_GROUP_A;
        5'd2:  vec_offset = `RIVM_VEC_PC_GROUP_B;
        5'd3:  vec_offset = `RIVM_VEC_TB8_COMPARE;
        5'd4:  vec_offset = `RIVM_VEC_TB8_OVERFLOW;
        5'd5:  vec_offset = `RIVM_VEC_TW16_CAPTURE;
        5'd6:  vec_offset = `RIVM_VEC_TW16_COMPARE_A;
        5'd7:  vec_offset = `RIVM_VEC_TW16_COMPARE_B;
        5'd8:  vec_offset = `RIVM_VEC_TW16_OVERFLOW;
        5'd9:  vec_offset = `RIVM_VEC_TA8_COMPARE;
        5'd10: vec_offset = `RIVM_VEC_TA8_OVERFLOW;
        5'd11: vec_offset = `RIVM_VEC_SPI_DONE;
        5'd12: vec_offset = `RIVM_VEC_USART_RX;
        5'd13: vec_offset = `RIVM_VEC_TX_BUF_EMPTY;
        5'd14: vec_offset = `RIVM_VEC_USART_TX;
        5'd15: vec_offset = `RIVM_VEC_USU_START;
        5'd16: vec_offset = `RIVM_VEC_USU_OVERFLOW;
        5'd17: vec_offset = `RIVM_VEC_ANALOG_COMP;
        5'd18: vec_offset = `RIVM_VEC_CONV_DONE;
        5'd19: vec_offset = `RIVM_VEC_EEPROM_READY;
        5'd20: vec_offset = `RIVM_VEC_PROG_STORE_RDY;
        5'd21: vec_offset = `RIVM_VEC_DISPLAY_FRAME;
        5'd22: vec_offset = `RIVM_VEC_PC_GROUP_C;
        5'd23: vec_offset = `RIVM_VEC_PC_GROUP_D;
        default: vec_offset = `RIVM_RESET_ADDR;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // source presence per variant
  // ----------------------------------------------------------------
  // small variants have no pin-change groups c and d; their lines are ignored
  wire [N_SRC-1:0] src_present;
  genvar g;
  generate
    for (g = 0; g < N_SRC; g = g + 1) begin : g_present
      if (g >= `RIVM_SRC_LARGE_FIRST && LARGE_PINS == 0) begin : g_absent
        assign src_present[g] = 1'b0;
      end else begin : g_here
        assign src_present[g] = 1'b1;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // reset address selection
  // ----------------------------------------------------------------
  reg started;
  reg [ADDR_W-1:0] next_reset_addr;

  always @* begin
    if (reset_location_fuse_i == `RIVM_FUSE_UNPROG) begin
      next_reset_addr = `RIVM_RESET_ADDR;
    end else begin
      next_reset_addr = boot_reset_addr_i;
    end
  end

  // fuse is a static strap, so it is resampled every cycle after release
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      started       <= 1'b0;
      reset_fetch_o <= 1'b0;
      reset_addr_o  <= `RIVM_RESET_ADDR;
    end else begin
      started       <= 1'b1;
      reset_fetch_o <= ~started;
      reset_addr_o  <= next_reset_addr;
    end
  end

  // ----------------------------------------------------------------
  // table select with timed unlock
  // ----------------------------------------------------------------
  reg [2:0] unlock_cnt;
  reg       wait_instr;
  wire      wr_unlock = ctrl_wr_i & ctrl_wdata_i[`RIVM_CTRL_UNLOCK_BIT];
  wire      wr_select = ctrl_wr_i & ~ctrl_wdata_i[`RIVM_CTRL_UNLOCK_BIT]
                        & vector_change_unlock_o;

  // a select write without a live unlock is dropped; that is the protection
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vector_table_select_o  <= `RIVM_CTRL_SELECT_RST;
      vector_change_unlock_o <= `RIVM_CTRL_UNLOCK_RST;
      unlock_cnt             <= 3'd0;
      wait_instr             <= 1'b0;
    end else begin
      if (wr_unlock) begin
        vector_change_unlock_o <= 1'b1;
        unlock_cnt             <= `RIVM_UNLOCK_CYCLES;
        wait_instr             <= 1'b0;
      end else if (wr_select) begin
        vector_table_select_o  <= ctrl_wdata_i[`RIVM_CTRL_SELECT_BIT];
        vector_change_unlock_o <= 1'b0;
        unlock_cnt             <= 3'd0;
        wait_instr             <= 1'b1;
      end else begin
        if (unlock_cnt == 3'd1) begin
          vector_change_unlock_o <= 1'b0;
        end
        if (unlock_cnt != 3'd0) begin
          unlock_cnt <= unlock_cnt - 3'd1;
        end
        if (wait_instr && instr_done_i) begin
          wait_instr <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt blocking
  // ----------------------------------------------------------------
  // blocking never touches the core's global enable flag
  reg next_blocked;

  always @* begin
    next_blocked = wr_unlock | wr_select | (unlock_cnt > 3'd1)
                   | (wait_instr & ~instr_done_i);
  end

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_blocked_o <= 1'b0;
    end else begin
      irq_blocked_o <= next_blocked;
    end
  end

  // ----------------------------------------------------------------
  // priority selection and address formation
  // ----------------------------------------------------------------
  wire [N_SRC-1:0] eligible = irq_src_i & src_present;
  wire             win_valid;
  wire [IDX_W-1:0] win_idx;

  rivm_prio_enc #(
    .N     (N_SRC),
    .IDX_W (IDX_W)
  ) u_prio (
    .req_i   (eligible),
    .valid_o (win_valid),
    .idx_o   (win_idx)
  );

  reg [ADDR_W-1:0] next_vec_addr;
  reg [ADDR_W-1:0] table_base;

  always @* begin
    if (vector_table_select_o) begin
      table_base = boot_reset_addr_i;
    end else begin
      table_base = {ADDR_W{1'b0}};
    end
    // offsets step by two words so each entry holds one long jump
    next_vec_addr = table_base + vec_offset(win_idx);
  end

  // ----------------------------------------------------------------
  // request to core and acknowledge fan-out
  // ----------------------------------------------------------------
  // vector is frozen while a request waits, so the core sees a stable pair
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_req_o         <= 1'b0;
      irq_vector_num_o  <= {IDX_W{1'b0}};
      irq_vector_addr_o <= `RIVM_RESET_ADDR;
      irq_ack_src_o     <= {N_SRC{1'b0}};
    end else begin
      irq_ack_src_o <= {N_SRC{1'b0}};
      if (irq_req_o && irq_ack_i) begin
        irq_req_o <= 1'b0;
        irq_ack_src_o[irq_vector_num_o] <= 1'b1;
      end else if (!irq_req_o) begin
        irq_req_o         <= win_valid & global_irq_enable_i & ~next_blocked;
        irq_vector_num_o  <= win_idx;
        irq_vector_addr_o <= next_vec_addr;
      end
    end
  end

endmodule // rivm_vector_map

// ---- tb/rivm_core_model.sv ----
// core model: accepts each interrupt request after a chosen delay
module rivm_core_model (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       irq_req_i,
  input  wire logic [3:0] ack_delay_i,
  output logic            irq_ack_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] wait_cnt;
  // ack stands one cycle, so the frozen request is never acked twice
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_cnt  <= 4'h0;
      irq_ack_o <= 1'b0;
    end else if (irq_req_i && !irq_ack_o && wait_cnt >= ack_delay_i) begin
      irq_ack_o <= 1'b1;
    end else begin
      irq_ack_o <= 1'b0;
      wait_cnt  <= (irq_req_i && !irq_ack_o) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule // rivm_core_model

// ---- tb/rivm_vector_map_props.sv ----
// property checker for the reset and interrupt vector map
`include "rivm_regs.vh"
module rivm_vector_map_props #(
  parameter ADDR_W     = 16,
  parameter N_SRC      = 24,
  parameter IDX_W      = 5,
  parameter LARGE_PINS = 1
) (
  input wire              core_clk_i,
  input wire              rst_b_i,
  input wire              reset_location_fuse_i,
  input wire [ADDR_W-1:0] boot_reset_addr_i,
  input wire              ctrl_wr_i,
  input wire [1:0]        ctrl_wdata_i,
  input wire              instr_done_i,
  input wire              global_irq_enable_i,
  input wire [N_SRC-1:0]  irq_src_i,
  input wire              irq_ack_i,
  input wire              reset_fetch_o,
  input wire [ADDR_W-1:0] reset_addr_o,
  input wire              vector_table_select_o,
  input wire              vector_change_unlock_o,
  input wire              irq_blocked_o,
  input wire              irq_req_o,
  input wire [IDX_W-1:0]  irq_vector_num_o,
  input wire [ADDR_W-1:0] irq_vector_addr_o,
  input wire [N_SRC-1:0]  irq_ack_src_o
);
  wire [N_SRC-1:0]  one_hot  = {{(N_SRC-1){1'b0}}, 1'b1} << irq_vector_num_o;
  wire [ADDR_W-1:0] tbl_base = vector_table_select_o ? boot_reset_addr_i : {ADDR_W{1'b0}};
  wire [ADDR_W-1:0] exp_vec  = tbl_base + `RIVM_VEC_STRIDE * (irq_vector_num_o + 1'b1);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // quiet window: no write may re-arm or close the unlock early
  sequence s_quiet_unlock;
    $rose(vector_change_unlock_o) ##0 (!ctrl_wr_i) [*4];
  endsequence
  sequence s_sel_write;
    ctrl_wr_i && !ctrl_wdata_i[0] && vector_change_unlock_o;
  endsequence
  a_fetch_after_reset: assert property ($rose(rst_b_i) |=> reset_fetch_o)
    else $error("no fetch after reset");
  a_reset_addr_pick: assert property (reset_fetch_o |-> reset_addr_o ==
    (reset_location_fuse_i ? `RIVM_RESET_ADDR : boot_reset_addr_i) ##1 !reset_fetch_o)
    else $error("wrong reset address");
  a_unlock_four_cycles: assert property (s_quiet_unlock |-> vector_change_unlock_o
    ##1 !vector_change_unlock_o) else $error("unlock lifetime wrong");
  a_select_write_ok: assert property (s_sel_write |=> !vector_change_unlock_o
    && vector_table_select_o == $past(ctrl_wdata_i[1]) && irq_blocked_o)
    else $error("select write mishandled");
  a_select_guarded: assert property ($changed(vector_table_select_o) |->
    $past(ctrl_wr_i && !ctrl_wdata_i[0] && vector_change_unlock_o))
    else $error("select changed without unlock");
  // blocked output lags the internal block by one edge, so it is read at the rise
  a_block_stops_req: assert property ($rose(irq_req_o) |->
    $past(global_irq_enable_i) && !irq_blocked_o) else $error("request while blocked");
  a_lowest_first: assert property ($rose(irq_req_o) |->
    ($past(irq_src_i) & (one_hot | (one_hot - 1'b1))) == one_hot)
    else $error("not lowest pending source");
  a_vector_address: assert property ($rose(irq_req_o) |-> irq_vector_addr_o == exp_vec)
    else $error("wrong vector address");
  a_req_hold: assert property (irq_req_o && !irq_ack_i |=> irq_req_o &&
    $stable(irq_vector_num_o) && $stable(irq_vector_addr_o)) else $error("request not held");
  a_ack_pulse: assert property (irq_req_o && irq_ack_i |=> !irq_req_o &&
    irq_ack_src_o == $past(one_hot) ##1 irq_ack_src_o == 0) else $error("bad ack pulse");
endmodule // rivm_vector_map_props

bind rivm_vector_map rivm_vector_map_props #(
  .ADDR_W(ADDR_W), .N_SRC(N_SRC), .IDX_W(IDX_W), .LARGE_PINS(LARGE_PINS)
) rivm_vector_map_props_i (.*);

// ---- tb/testbench.sv ----
// self-checking bench for the reset and interrupt vector map
`include "rivm_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        reset_location_fuse_i = 1'b1;
  logic [15:0] boot_reset_addr_i = 16'h0100;
  logic        ctrl_wr_i = 1'b0;
  logic [1:0]  ctrl_wdata_i = 2'h0;
  logic        instr_done_i = 1'b0;
  logic        global_irq_enable_i = 1'b0;
  logic [23:0] irq_src_i = 24'h0;
  logic [3:0]  ack_delay = 4'h0;
  logic        irq_ack_i, reset_fetch_o, vector_table_select_o;
  logic        vector_change_unlock_o, irq_blocked_o, irq_req_o;
  logic [15:0] reset_addr_o, irq_vector_addr_o;
  logic [4:0]  irq_vector_num_o;
  logic [23:0] irq_ack_src_o;
  logic        exp_sel;
  int          bad_count = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          seed;

  rivm_vector_map rivm_vector_map_i (.*);
  rivm_core_model rivm_core_model_i (.clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .irq_req_i(irq_req_o), .ack_delay_i(ack_delay), .irq_ack_o(irq_ack_i));
  logic        small_req;
  // small variant: pin-change groups c and d must never raise a request
  rivm_vector_map #(.LARGE_PINS(0)) rivm_vector_map_small_i (.core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i), .reset_location_fuse_i(reset_location_fuse_i),
    .boot_reset_addr_i(boot_reset_addr_i), .ctrl_wr_i(ctrl_wr_i), .ctrl_wdata_i(ctrl_wdata_i),
    .instr_done_i(instr_done_i), .global_irq_enable_i(global_irq_enable_i),
    .irq_src_i(irq_src_i), .irq_ack_i(1'b0), .reset_fetch_o(), .reset_addr_o(),
    .vector_table_select_o(), .vector_change_unlock_o(), .irq_blocked_o(),
    .irq_req_o(small_req), .irq_vector_num_o(), .irq_vector_addr_o(), .irq_ack_src_o());

  initial forever #2.5 core_clk_i = ~core_clk_i;
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic chk(input logic ok, input string what);
    total_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  function automatic logic [15:0] vec_of(input logic s, input int idx);
    return (s ? boot_reset_addr_i : 16'h0000) + `RIVM_VEC_STRIDE * (idx + 1);
  endfunction
  function automatic int lowest(input logic [23:0] b);
    lowest = 0;
    for (int k = 23; k >= 0; k--)
      if (b[k]) lowest = k;
  endfunction
  task automatic do_reset(input logic f);
    rst_b_i = 1'b0;
    reset_location_fuse_i = f;
    boot_reset_addr_i = 16'($urandom_range(255, 1)) << 8;
    exp_sel = 1'b0;
    tick(8);
    rst_b_i = 1'b1;
    tick(1);
    chk(reset_fetch_o === 1'b1, "no reset fetch");
    chk(reset_addr_o === (f ? `RIVM_RESET_ADDR : boot_reset_addr_i), "reset addr");
    chk(vector_table_select_o === 1'b0, "select after reset");
    tick(1);
    chk(reset_fetch_o === 1'b0, "fetch too long");
  endtask
  task automatic ctrl(input logic [1:0] d);
    ctrl_wr_i = 1'b1;
    ctrl_wdata_i = d;
    tick(1);
    ctrl_wr_i = 1'b0;
  endtask
  task automatic irq_case(input logic [23:0] bits);
    int want;
    want = lowest(bits);
    irq_src_i = bits;
    global_irq_enable_i = 1'b1;
    ack_delay = 4'($urandom_range(7, 0));
    for (int t = 0; t < 40 && irq_req_o !== 1'b1; t++) tick(1);
    irq_src_i = 24'h0;
    chk(irq_vector_num_o === 5'(want), "vector number");
    chk(irq_vector_addr_o === vec_of(exp_sel, want), "vector address");
    for (int t = 0; t < 40 && irq_ack_src_o === 24'h0; t++) tick(1);
    chk(irq_ack_src_o === 24'h1 << want, "ack source");
    tick(1);
  endtask
  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    seed = $urandom(87);
    do_reset(1'b1);
    end_test("reset unprogrammed");
    for (int i = 0; i < 24; i++) irq_case(24'h1 << i);
    end_test("each vector");
    global_irq_enable_i = 1'b0;
    irq_src_i = 24'($urandom) | 24'h000800;
    tick(6);
    chk(irq_req_o === 1'b0, "request with interrupts off");
    for (int i = 0; i < 20; i++) irq_case((24'($urandom) << $urandom_range(20, 0)) | 24'h800000);
    end_test("priority");
    ctrl(2'b01);
    chk(vector_change_unlock_o === 1'b1 && irq_blocked_o === 1'b1, "unlock");
    tick(1);
    ctrl(2'b10);
    exp_sel = 1'b1;
    chk(vector_table_select_o === 1'b1 && vector_change_unlock_o === 1'b0, "select");
    tick(2);
    chk(irq_blocked_o === 1'b1, "block ended early");
    instr_done_i = 1'b1;
    tick(1);
    instr_done_i = 1'b0;
    tick(1);
    chk(irq_blocked_o === 1'b0, "block stuck");
    ctrl(2'b01);
    irq_src_i = 24'h000001;
    tick(2);
    chk(vector_change_unlock_o === 1'b1 && irq_req_o === 1'b0, "req while blocked");
    tick(1);
    chk(vector_change_unlock_o === 1'b1, "unlock short");
    tick(1);
    chk(vector_change_unlock_o === 1'b0, "unlock long");
    chk(irq_req_o === 1'b1 && irq_vector_addr_o === vec_of(1'b1, 0), "req after block");
    irq_src_i = 24'h0;
    for (int t = 0; t < 40 && irq_ack_src_o === 24'h0; t++) tick(1);
    tick(1);
    tick(1);
    ctrl(2'b00);
    chk(vector_table_select_o === 1'b1, "select without unlock");
    for (int i = 0; i < 8; i++) irq_case(24'h1 << $urandom_range(23, 0));
    end_test("relocation");
    global_irq_enable_i = 1'b0;
    do_reset(1'b0);
    irq_case(24'h400000);
    chk(small_req === 1'b0, "absent source raised");
    end_test("boot reset");
    finish_test();
  end
endmodule // testbench
